/* File: include/thl_pkg.sv */
// Package: constants for the print head line loader
`default_nettype none
package thl_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned LINE_BITS      = 256;
  localparam int unsigned LINE_BYTES     = 32;
  localparam int unsigned BYTE_W         = 8;
  localparam int unsigned FIFO_DEPTH     = 8;
  localparam int unsigned TMR_W          = 16;
  // Serial clock half period, least time
  localparam int unsigned SCLK_HALF_NS   = 40;
  localparam int unsigned SCLK_HALF_CYC  = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Latch pulse width, least time
  localparam int unsigned LATCH_NS       = 100;
  localparam int unsigned LATCH_CYC      = (LATCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Strobe (heating) time, least time
  localparam int unsigned STROBE_NS      = 2000;
  localparam int unsigned STROBE_CYC     = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0]  LAST_BIT       = 9'h0ff;
  localparam logic [8:0]  BITS_PER_LINE  = 9'h100;

  typedef enum logic [2:0] {
    THL_FETCH  = 3'b000,
    THL_LOW    = 3'b001,
    THL_HIGH   = 3'b010,
    THL_LATCH  = 3'b011,
    THL_STROBE = 3'b100
  } thl_state_t;
endpackage : thl_pkg
`default_nettype wire

/* File: include/thl_stream_if.sv */
// Interface: valid/ready byte stream between loader parts
`default_nettype none
interface thl_stream_if #(parameter int WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : thl_stream_if
`default_nettype wire

/* File: hdl/thl_fifo.sv */
// Module: synchronous FIFO with registered full and empty flags
`default_nettype none
module thl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic   core_clk,
  input  wire logic   srst,
  thl_stream_if.snk   wr,
  thl_stream_if.src   rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      cnt_ff;
  logic [AW:0]      nxt_cnt;
  logic             not_full_ff;
  logic             not_empty_ff;
  logic             push;
  logic             pop;

  assign push     = wr.valid && not_full_ff;
  assign pop      = rd.ready && not_empty_ff;
  assign wr.ready = not_full_ff;
  assign rd.valid = not_empty_ff;
  assign rd.data  = mem[rd_ptr_ff];

  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= wr.data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_ptr_ff    <= '0;
      rd_ptr_ff    <= '0;
      cnt_ff       <= '0;
      not_full_ff  <= 1'b1;
      not_empty_ff <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      cnt_ff       <= nxt_cnt;
      not_full_ff  <= (nxt_cnt != (AW+1)'(DEPTH));
      not_empty_ff <= (nxt_cnt != '0);
    end
  end
endmodule : thl_fifo
`default_nettype wire

/* File: hdl/thl_line_loader.sv */
// Module: loads one print line into the thermal print head and fires it
`default_nettype none
module thl_line_loader
  import thl_pkg::*;
#(
  parameter int unsigned SCLK_HALF  = thl_pkg::SCLK_HALF_CYC,
  parameter int unsigned LATCH_LEN  = thl_pkg::LATCH_CYC,
  parameter int unsigned STROBE_LEN = thl_pkg::STROBE_CYC,
  parameter int          DEPTH      = thl_pkg::FIFO_DEPTH
) (
  input  wire logic                      core_clk,
  input  wire logic                      srst,
  input  wire logic                      in_valid,
  input  wire logic [thl_pkg::BYTE_W-1:0] in_data,
  output var  logic                      in_ready,
  output var  logic                      head_sclk,
  output var  logic                      head_sdata,
  output var  logic                      head_latch,
  output var  logic                      strobe_group_one,
  output var  logic                      strobe_group_two,
  output var  logic                      line_busy,
  output var  logic                      line_done
);
  import thl_pkg::*;

  thl_stream_if #(.WIDTH(BYTE_W)) wr_if ();
  thl_stream_if #(.WIDTH(BYTE_W)) rd_if ();

  thl_state_t        state_ff;
  logic [TMR_W-1:0]  tmr_ff;
  logic [8:0]        bit_ff;
  logic [BYTE_W-1:0] sh_ff;
  logic              tmr_done;
  logic [8:0]        bits_seen_ff;

  // ------------------------------------------------------------
  // Byte buffer
  // ------------------------------------------------------------
  assign wr_if.valid = in_valid && in_ready;
  assign wr_if.data  = in_data;
  assign rd_if.ready = (state_ff == THL_FETCH);

  thl_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .srst     (srst),
    .wr       (wr_if),
    .rd       (rd_if)
  );

  // Bytes enter only while ready; ready drops after each accept,
  // so a registered ready can never admit into a full buffer.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      in_ready <= 1'b0;
    end else begin
      in_ready <= wr_if.ready && !(wr_if.valid && wr_if.ready);
    end
  end

  // ------------------------------------------------------------
  // Phase timer
  // ------------------------------------------------------------
  assign tmr_done = (tmr_ff == '0);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tmr_ff <= '0;
    end else if (state_ff == THL_FETCH && rd_if.valid) begin
      tmr_ff <= TMR_W'(SCLK_HALF - 1);
    end else if (!tmr_done) begin
      tmr_ff <= tmr_ff - 1'b1;
    end else begin
      unique case (state_ff)
        THL_LOW:    tmr_ff <= TMR_W'(SCLK_HALF - 1);
        THL_HIGH:   tmr_ff <= (bit_ff == LAST_BIT) ? TMR_W'(LATCH_LEN - 1) : TMR_W'(SCLK_HALF - 1);
        THL_LATCH:  tmr_ff <= TMR_W'(STROBE_LEN - 1);
        THL_FETCH:  tmr_ff <= '0;
        THL_STROBE: tmr_ff <= '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Line sequencer
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_ff         <= THL_FETCH;
      bit_ff           <= '0;
      sh_ff            <= '0;
      head_sclk        <= 1'b0;
      head_sdata       <= 1'b0;
      head_latch       <= 1'b0;
      strobe_group_one <= 1'b0;
      strobe_group_two <= 1'b0;
      line_done        <= 1'b0;
    end else begin
      line_done <= 1'b0;
      unique case (state_ff)
        THL_FETCH: begin
          if (rd_if.valid) begin
            sh_ff      <= rd_if.data;
            head_sdata <= rd_if.data[BYTE_W-1];
            state_ff   <= THL_LOW;
          end
        end
        THL_LOW: begin
          if (tmr_done) begin
            head_sclk <= 1'b1;
            state_ff  <= THL_HIGH;
          end
        end
        THL_HIGH: begin
          if (tmr_done) begin
            head_sclk <= 1'b0;
            if (bit_ff == LAST_BIT) begin
              bit_ff     <= '0;
              head_latch <= 1'b1;
              state_ff   <= THL_LATCH;
            end else begin
              bit_ff <= bit_ff + 1'b1;
              if (bit_ff[2:0] == 3'h7) begin
                state_ff <= THL_FETCH;
              end else begin
                sh_ff      <= {sh_ff[BYTE_W-2:0], 1'b0};
                head_sdata <= sh_ff[BYTE_W-2];
                state_ff   <= THL_LOW;
              end
            end
          end
        end
        THL_LATCH: begin
          if (tmr_done) begin
            head_latch       <= 1'b0;
            strobe_group_one <= 1'b1;
            strobe_group_two <= 1'b1;
            state_ff         <= THL_STROBE;
          end
        end
        THL_STROBE: begin
          if (tmr_done) begin
            strobe_group_one <= 1'b0;
            strobe_group_two <= 1'b0;
            line_done        <= 1'b1;
            state_ff         <= THL_FETCH;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      line_busy <= 1'b0;
    end else begin
      line_busy <= (state_ff != THL_FETCH) || (bit_ff != '0) || rd_if.valid;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst || head_latch) begin
      bits_seen_ff <= '0;
    end else if (head_sclk && state_ff == THL_HIGH && tmr_done) begin
      bits_seen_ff <= bits_seen_ff + 1'b1;
    end
  end

  chk_bits_per_line: assert property (@(posedge core_clk) disable iff (srst)
    $rose(head_latch) |-> bits_seen_ff == BITS_PER_LINE)
    else $error("latch without 256 clocked bits");

  chk_latch_after_shift: assert property (@(posedge core_clk) disable iff (srst)
    $rose(head_latch) |-> $past(state_ff) == THL_HIGH && !head_sclk)
    else $error("latch not after final serial clock");

  chk_strobe_after_latch: assert property (@(posedge core_clk) disable iff (srst)
    $fell(head_latch) |-> strobe_group_one && strobe_group_two)
    else $error("strobe did not follow latch");

  chk_groups_equal: assert property (@(posedge core_clk) disable iff (srst)
    strobe_group_one == strobe_group_two)
    else $error("strobe groups differ");

  chk_latch_no_strobe: assert property (@(posedge core_clk) disable iff (srst)
    head_latch |-> !strobe_group_one && !strobe_group_two)
    else $error("latch while strobing");

  chk_data_stable: assert property (@(posedge core_clk) disable iff (srst)
    $rose(head_sclk) |-> $stable(head_sdata) ##1 $stable(head_sdata))
    else $error("serial data moved at clock edge");

  chk_sclk_width: assert property (@(posedge core_clk) disable iff (srst)
    $rose(head_sclk) |-> head_sclk [*8])
    else $error("serial clock high too short");

  chk_strobe_width: assert property (@(posedge core_clk) disable iff (srst)
    $rose(strobe_group_one) |-> strobe_group_one [*8])
    else $error("strobe too short");

  chk_done_pulse: assert property (@(posedge core_clk) disable iff (srst)
    line_done |-> $past(strobe_group_one) && !strobe_group_one ##1 !line_done)
    else $error("line done not a single pulse after strobe");

  chk_accept_spacing: assert property (@(posedge core_clk) disable iff (srst)
    in_valid && in_ready |=> !in_ready)
    else $error("byte taken on two cycles in a row");
endmodule : thl_line_loader
`default_nettype wire

/* File: tb/thl_head_model.sv */
// Head model: two shift registers on one data line and a latch register
`default_nettype none
module thl_head_model (
  input wire logic sclk,
  input wire logic sdata,
  input wire logic latch,
  input wire logic stb_one,
  input wire logic stb_two
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [255:0] sr_one    = '0;
  logic [255:0] sr_two    = '0;
  logic [511:0] latch_reg = '0;
  int           bit_cnt   = 0;
  int           fires     = 0;
  int           fires_two = 0;
  // -----------------------------------------------------------
  // Shifting: shorted data inputs feed both registers
  // -----------------------------------------------------------
  always @(posedge sclk) begin
    sr_one  <= {sr_one[254:0], sdata};
    sr_two  <= {sr_two[254:0], sdata};
    bit_cnt <= bit_cnt + 1;
  end
  // -----------------------------------------------------------
  // Latch and heating
  // -----------------------------------------------------------
  always @(posedge latch) begin
    latch_reg <= {sr_two, sr_one};
  end
  always @(posedge stb_one) begin
    fires <= fires + 1;
  end
  always @(posedge stb_two) begin
    fires_two <= fires_two + 1;
  end
endmodule : thl_head_model
`default_nettype wire

/* File: tb/tb_thl_line_loader.sv */
// Testbench: line loading, fifo refusal, mid-line stall
`default_nettype none
module tb_thl_line_loader;
  timeunit 1ns;
  timeprecision 1ps;
  import thl_pkg::*;
  logic       core_clk, srst, in_valid;
  logic [7:0] in_data;
  logic       in_ready, head_sclk, head_sdata, head_latch, strobe_group_one, strobe_group_two, line_busy, line_done;
  logic       prev_sclk, prev_sdata;
  logic [255:0] exp_line;
  int bad_count = 0, comparisons = 0, refusals = 0, latches = 0, strobes = 0;

  thl_line_loader #(.SCLK_HALF(8), .LATCH_LEN(2), .STROBE_LEN(8), .DEPTH(8)) i_thl_line_loader (
    .core_clk(core_clk), .srst(srst), .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
    .head_sclk(head_sclk), .head_sdata(head_sdata), .head_latch(head_latch), .strobe_group_one(strobe_group_one),
    .strobe_group_two(strobe_group_two), .line_busy(line_busy), .line_done(line_done));
  thl_head_model i_thl_head_model (.sclk(head_sclk), .sdata(head_sdata), .latch(head_latch),
    .stb_one(strobe_group_one), .stb_two(strobe_group_two));

  task automatic print_verdict();
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic chk(input bit ok, input string msg);
    comparisons++;
    if (!ok) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic send_byte(input logic [7:0] b);
    int n;
    n = 0;
    @(negedge core_clk);
    in_valid = 1'b1;
    in_data  = b;
    do begin
      @(posedge core_clk);
      if (in_ready !== 1'b1) refusals++;
      n++;
    end while (in_ready !== 1'b1 && n < 5000);
    @(negedge core_clk);
    in_valid = 1'b0;
    if (n >= 5000) begin
      chk(1'b0, "byte never accepted");
      print_verdict();
    end
  endtask : send_byte

  task automatic wait_line(input int line_no);
    int n;
    n = 0;
    while (line_done !== 1'b1 && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    chk(n < 20000, "line never done");
    if (n >= 20000) print_verdict();
    chk(i_thl_head_model.latch_reg === {exp_line, exp_line}, "latched pattern");
    chk(i_thl_head_model.bit_cnt == 256 * line_no, "bit count per line");
    chk(i_thl_head_model.fires == line_no, "one strobe per line");
    chk(i_thl_head_model.fires_two == line_no, "group two strobe count");
  endtask : wait_line

  // Full line offered as fast as allowed: fifo fills and refuses
  task automatic line_flood();
    for (int i = 0; i < 32; i++) begin
      exp_line = {exp_line[247:0], 8'h5a ^ 8'(i * 37)};
      send_byte(8'h5a ^ 8'(i * 37));
    end
    chk(refusals > 0, "full fifo never refused");
    chk(line_busy === 1'b1, "busy while line in progress");
    wait_line(1);
    @(negedge core_clk);
    chk(line_busy === 1'b0, "busy after line done");
  endtask : line_flood

  // Input starves mid-line: head clock halts, no early latch
  task automatic line_stall();
    for (int i = 0; i < 32; i++) begin
      if (i == 16) begin
        repeat (2600) @(posedge core_clk);
        chk(i_thl_head_model.bit_cnt == 256 + 128, "bits before stall");
        chk(line_busy === 1'b1, "busy during stall");
        repeat (40) begin
          @(negedge core_clk);
          chk(head_sclk === 1'b0 && head_latch === 1'b0, "clock or latch during stall");
        end
      end
      exp_line = {exp_line[247:0], 8'(8'hc3 + i * 8'h11)};
      send_byte(8'(8'hc3 + i * 8'h11));
    end
    wait_line(2);
  endtask : line_stall

  // -----------------------------------------------------------
  // Continuous watch of the head lines
  // -----------------------------------------------------------
  always @(posedge core_clk) begin
    prev_sclk  <= head_sclk;
    prev_sdata <= head_sdata;
    if (!srst) begin
      if (strobe_group_one !== strobe_group_two) chk(1'b0, "strobe groups differ");
      if (head_latch === 1'b1 && strobe_group_one === 1'b1) chk(1'b0, "latch during strobe");
      if (head_sclk === 1'b1 && prev_sclk === 1'b1 && head_sdata !== prev_sdata) chk(1'b0, "sdata moved");
    end
  end
  always @(posedge head_latch) begin
    latches++;
    chk(i_thl_head_model.bit_cnt == 256 * latches, "latch before full transfer");
  end
  always @(posedge strobe_group_one) begin
    strobes++;
    chk(latches == strobes && head_latch === 1'b0, "strobe without latch");
  end

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  initial begin
    srst     = 1'b1;
    in_valid = 1'b0;
    in_data  = 8'h00;
    exp_line = '0;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    line_flood();
    line_stall();
    print_verdict();
  end
endmodule : tb_thl_line_loader
`default_nettype wire
